// ### verilog/power_mode_regs.vh
// Register offsets, field positions, reset values and timing counts for the power mode controller
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH
`define PM_ADDR_MISC_CONTROL_ONE 4'h0
`define PM_ADDR_MAIN_CLOCK_STATUS_CONTROL 4'h1
`define PM_ADDR_CPU_CONTROL 4'h2
`define PM_ADDR_STATUS 4'h3
`define PM_ADDR_WAKE_MASK 4'h4
`define PM_MISC_SLOW_ENABLE_BIT 2
`define PM_MISC_DIV_LSB 0
`define PM_MAIN_CLOCK_STATUS_CONTROL_OIE_BIT 0
`define PM_CPU_WDG_HALT_OPT_BIT 0
`define PM_RESET_MISC 8'h00
`define PM_RESET_MAIN_CLOCK_STATUS_CONTROL 8'h00
`define PM_RESET_WAKE_MASK 16'hFFFF
`define PM_WAKE_DELAY_CYCLES 4096
`define PM_NORMAL_DIV_LOG2 1
`define PM_ILEVEL_ENABLED 2'h2
`endif

// ### verilog/clock_divider.v
// Programmable oscillator divider giving the CPU and peripheral clock enables
`timescale 1ns/1ns
module clock_divider #(
  parameter WIDTH = 5
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire [2:0] log2_div_i,
  output reg tick_o
);
  reg [WIDTH-1:0] count_q;
  wire [WIDTH-1:0] last_w;

  // Terminal count is divisor minus one
  assign last_w = (({{(WIDTH-1){1'b0}}, 1'b1} << log2_div_i) - {{(WIDTH-1){1'b0}}, 1'b1});

  // Free counter, stopped while oscillator is off
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count_q <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else if (count_q >= last_w) begin
      count_q <= {WIDTH{1'b0}};
      tick_o <= 1'b1;
    end else begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule // clock_divider

// ### verilog/power_saving_mode_controller.v
// Power saving mode controller: run, slow, wait, active-halt and halt sequencing
`timescale 1ns/1ns
`include "power_mode_regs.vh"
module power_saving_mode_controller #(
  parameter WAKE_DELAY = `PM_WAKE_DELAY_CYCLES,
  parameter NUM_IRQ = 14
) (
  input wire CLK_I,
  input wire RST_N_I,
  // Classic Wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [3:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  output wire ERR_O,
  // CPU core
  input wire WFI_I,
  input wire HALT_I,
  input wire [1:0] CPU_ILEVEL_I,
  input wire [1:0] IRQ_PRIORITY_I,
  output reg CPU_CLK_EN_O,
  output reg PERIPH_CLK_EN_O,
  output reg OSC_RUN_O,
  output reg TIMEBASE_CLK_EN_O,
  output reg ILEVEL_FORCE_O,
  output reg [1:0] ILEVEL_O,
  output reg SERVICE_IRQ_O,
  output reg FETCH_RESET_O,
  output reg PUSH_CC_O,
  // Interrupt sources, watchdog
  input wire [NUM_IRQ-1:0] IRQ_PENDING_I,
  input wire TIMEBASE_IRQ_I,
  input wire WAKE_RESET_I,
  input wire WATCHDOG_ACTIVE_I,
  output reg WATCHDOG_RESET_O,
  output reg [2:0] MODE_O
);
  // Modes
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_ACTIVE_HALT = 3'h2;
  localparam [2:0] ST_HALT = 3'h3;
  localparam [2:0] ST_DELAY = 3'h4;
  localparam integer DELAY_LAST_INT = WAKE_DELAY - 1;
  localparam [12:0] DELAY_LAST = DELAY_LAST_INT[12:0];
  // Reset images of the control words
  localparam [7:0] MISC_RESET = `PM_RESET_MISC;
  localparam [7:0] MAIN_CLOCK_STATUS_CONTROL_RESET = `PM_RESET_MAIN_CLOCK_STATUS_CONTROL;
  localparam [15:0] WAKE_MASK_RESET = `PM_RESET_WAKE_MASK;
  localparam [2:0] NORMAL_LOG2 = `PM_NORMAL_DIV_LOG2;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg slow_mode_enable_q;
  reg [1:0] slow_divider_select_q;
  reg oscillator_interrupt_enable_q;
  reg watchdog_halt_option_q;
  reg [NUM_IRQ-1:0] wake_mask_q;
  reg [12:0] delay_q;
  reg wake_by_reset_q;
  reg wake_by_reset_d;
  reg clear_delay;
  reg [2:0] log2_div;
  wire cpu_tick;
  wire [NUM_IRQ-1:0] irq_capable;
  wire any_irq;
  wire halt_wake;
  wire active_wake;
  wire bus_req;
  wire resume;
  wire wait_wake;
  wire wr_lane0;
  wire wr_lane1;

  // Divider field to log2 of divisor
  function [2:0] div_log2;
    input slow;
    input [1:0] sel;
    begin
      if (slow) begin
        div_log2 = {1'b0, sel} + 3'h2;
      end else begin
        div_log2 = NORMAL_LOG2;
      end
    end
  endfunction

  // Modes in which the CPU clock runs
  function cpu_runs;
    input [2:0] st;
    begin
      cpu_runs = (st == ST_RUN);
    end
  endfunction

  // Modes in which ordinary peripherals run
  function periph_runs;
    input [2:0] st;
    begin
      periph_runs = (st == ST_RUN) || (st == ST_WAIT);
    end
  endfunction

  // Choice of divisor, slow kept through wait
  always @* begin
    log2_div = div_log2(slow_mode_enable_q, slow_divider_select_q);
  end

  clock_divider #(
    .WIDTH(5)
  ) u_div (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(OSC_RUN_O),
    .log2_div_i(log2_div),
    .tick_o(cpu_tick)
  );

  // Wake sources per halt state
  assign irq_capable = IRQ_PENDING_I & wake_mask_q;
  assign any_irq = |IRQ_PENDING_I;
  assign halt_wake = (|irq_capable) || WAKE_RESET_I;
  assign active_wake = halt_wake || TIMEBASE_IRQ_I;
  // Wait ends on any interrupt, mask ignored
  assign wait_wake = any_irq || TIMEBASE_IRQ_I || WAKE_RESET_I;

  // Mode sequencing
  always @* begin
    state_d = state_q;
    wake_by_reset_d = wake_by_reset_q;
    clear_delay = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (HALT_I) begin
          state_d = oscillator_interrupt_enable_q ? ST_ACTIVE_HALT : ST_HALT;
        end else if (WFI_I) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_wake) begin
          state_d = ST_RUN;
          wake_by_reset_d = WAKE_RESET_I;
        end
      end
      ST_ACTIVE_HALT: begin
        if (active_wake) begin
          state_d = ST_DELAY;
          wake_by_reset_d = WAKE_RESET_I;
          clear_delay = 1'b1;
        end
      end
      ST_HALT: begin
        if (halt_wake) begin
          state_d = ST_DELAY;
          wake_by_reset_d = WAKE_RESET_I;
          clear_delay = 1'b1;
        end
      end
      ST_DELAY: begin
        if (cpu_tick && delay_q == DELAY_LAST) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State and wake cause
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_RUN;
      wake_by_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_by_reset_q <= wake_by_reset_d;
    end
  end

  // Wake delay counter, CPU cycles
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      delay_q <= 13'h0000;
    end else begin
      if (clear_delay) begin
        delay_q <= 13'h0000;
      end else if (state_q == ST_DELAY && cpu_tick) begin
        delay_q <= delay_q + 13'h0001;
      end
    end
  end

  // CPU restarts in this cycle
  assign resume = !cpu_runs(state_q) && cpu_runs(state_d);

  // Mode report and oscillator control
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      MODE_O <= ST_RUN;
      OSC_RUN_O <= 1'b1;
    end else begin
      MODE_O <= state_d;
      OSC_RUN_O <= (state_d != ST_HALT);
    end
  end

  // Clock enables per mode
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CPU_CLK_EN_O <= 1'b0;
      PERIPH_CLK_EN_O <= 1'b0;
      TIMEBASE_CLK_EN_O <= 1'b0;
    end else begin
      CPU_CLK_EN_O <= cpu_runs(state_d) && cpu_tick;
      PERIPH_CLK_EN_O <= periph_runs(state_d) && cpu_tick;
      TIMEBASE_CLK_EN_O <= (state_d != ST_HALT) && cpu_tick;
    end
  end

  // Level forced to 10 on entry, routine priority on resume by interrupt, 10 on resume by reset
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ILEVEL_FORCE_O <= 1'b0;
      ILEVEL_O <= 2'h0;
    end else begin
      ILEVEL_FORCE_O <= cpu_runs(state_q) && !cpu_runs(state_d);
      if (resume && !wake_by_reset_d) begin
        ILEVEL_O <= IRQ_PRIORITY_I;
      end else begin
        ILEVEL_O <= `PM_ILEVEL_ENABLED;
      end
    end
  end

  // Resume: reset vector or interrupt service with CC push
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SERVICE_IRQ_O <= 1'b0;
      FETCH_RESET_O <= 1'b0;
      PUSH_CC_O <= 1'b0;
    end else begin
      FETCH_RESET_O <= resume && wake_by_reset_d;
      SERVICE_IRQ_O <= resume && !wake_by_reset_d;
      PUSH_CC_O <= resume && !wake_by_reset_d;
    end
  end

  // Watchdog on halt: option bit, none in active-halt
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      WATCHDOG_RESET_O <= 1'b0;
    end else begin
      WATCHDOG_RESET_O <= (state_q == ST_RUN) && HALT_I && WATCHDOG_ACTIVE_I &&
                          !oscillator_interrupt_enable_q && !watchdog_halt_option_q;
    end
  end

  // Wishbone register writes
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign ERR_O = 1'b0;
  assign wr_lane0 = bus_req && WE_I && SEL_I[0];
  assign wr_lane1 = bus_req && WE_I && SEL_I[1];

  // Acknowledge one cycle after the request is taken
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= bus_req;
    end
  end

  // Control register writes
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      slow_mode_enable_q <= MISC_RESET[`PM_MISC_SLOW_ENABLE_BIT];
      slow_divider_select_q <= MISC_RESET[`PM_MISC_DIV_LSB +: 2];
      oscillator_interrupt_enable_q <= MAIN_CLOCK_STATUS_CONTROL_RESET[`PM_MAIN_CLOCK_STATUS_CONTROL_OIE_BIT];
      watchdog_halt_option_q <= 1'b1;
      wake_mask_q <= WAKE_MASK_RESET[NUM_IRQ-1:0];
    end else begin
      if (wr_lane0) begin
        case (ADR_I)
          `PM_ADDR_MISC_CONTROL_ONE: begin
            slow_mode_enable_q <= DAT_I[`PM_MISC_SLOW_ENABLE_BIT];
            slow_divider_select_q <= DAT_I[`PM_MISC_DIV_LSB +: 2];
          end
          `PM_ADDR_MAIN_CLOCK_STATUS_CONTROL: begin
            oscillator_interrupt_enable_q <= DAT_I[`PM_MAIN_CLOCK_STATUS_CONTROL_OIE_BIT];
          end
          `PM_ADDR_CPU_CONTROL: begin
            watchdog_halt_option_q <= DAT_I[`PM_CPU_WDG_HALT_OPT_BIT];
          end
          `PM_ADDR_WAKE_MASK: begin
            wake_mask_q[7:0] <= DAT_I[7:0];
          end
          default: begin
          end
        endcase
      end
      if (wr_lane1 && ADR_I == `PM_ADDR_WAKE_MASK) begin
        wake_mask_q[NUM_IRQ-1:8] <= DAT_I[NUM_IRQ-1:8];
      end
    end
  end

  // Wishbone read data, unmapped reads zero
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DAT_O <= 32'h00000000;
    end else if (bus_req && !WE_I) begin
      case (ADR_I)
        `PM_ADDR_MISC_CONTROL_ONE: DAT_O <= {29'h0, slow_mode_enable_q, slow_divider_select_q};
        `PM_ADDR_MAIN_CLOCK_STATUS_CONTROL: DAT_O <= {31'h0, oscillator_interrupt_enable_q};
        `PM_ADDR_CPU_CONTROL: DAT_O <= {31'h0, watchdog_halt_option_q};
        `PM_ADDR_STATUS: DAT_O <= {16'h0, CPU_ILEVEL_I, 1'b0, delay_q[12:0]} | {29'h0, state_q};
        `PM_ADDR_WAKE_MASK: DAT_O <= {{(32-NUM_IRQ){1'b0}}, wake_mask_q};
        default: DAT_O <= 32'h00000000;
      endcase
    end
  end
endmodule // power_saving_mode_controller

// ### verification/cpu_core_model.sv
// Condition code level model standing in for the CPU core
`timescale 1ns/1ns
module cpu_core_model #(
  parameter [1:0] PRIO = 2'h1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire force_i,
  input wire [1:0] level_i,
  input wire push_i,
  output reg [1:0] level_o,
  output wire [1:0] prio_o
);
  // Priority of the routine that wakes
  assign prio_o = PRIO;
  // Level bits load whatever the controller forces or pushes
  always @(posedge clk_i) begin
    if (!rst_n_i)
      level_o <= 2'h3;
    else if (force_i || push_i)
      level_o <= level_i;
  end
endmodule // cpu_core_model

// ### verification/pm_props.sv
// Checker for the power mode controller outputs
`timescale 1ns/1ns
module pm_props #(
  parameter WAKE_DELAY = 8,
  parameter NUM_IRQ = 14
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire WFI_I,
  input wire HALT_I,
  input wire [1:0] IRQ_PRIORITY_I,
  input wire CPU_CLK_EN_O,
  input wire PERIPH_CLK_EN_O,
  input wire OSC_RUN_O,
  input wire ILEVEL_FORCE_O,
  input wire [1:0] ILEVEL_O,
  input wire SERVICE_IRQ_O,
  input wire PUSH_CC_O,
  input wire [NUM_IRQ-1:0] IRQ_PENDING_I,
  input wire WAKE_RESET_I,
  input wire WATCHDOG_ACTIVE_I,
  input wire WATCHDOG_RESET_O,
  input wire [2:0] MODE_O
);
  localparam int MAXD = 32 * WAKE_DELAY + 4;
  reg [15:0] dly_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Cycles spent in the wake delay
  always @(posedge CLK_I) begin
    if (!RST_N_I || MODE_O != 3'h4)
      dly_q <= 16'h0;
    else
      dly_q <= dly_q + 16'h1;
  end
  a_wait_entry: assert property (MODE_O == 3'h0 && WFI_I && !HALT_I && !WAKE_RESET_I
    && IRQ_PENDING_I == 0 |=> MODE_O == 3'h1) else $error("wait not entered");
  a_halt_entry: assert property (MODE_O == 3'h0 && HALT_I && !WAKE_RESET_I
    |=> MODE_O inside {3'h2, 3'h3, 3'h4}) else $error("halt not entered");
  a_wait_cpu_off: assert property (MODE_O == 3'h1 |-> !CPU_CLK_EN_O)
    else $error("cpu clocked in wait");
  a_ahalt_clocks: assert property (MODE_O == 3'h2 |-> OSC_RUN_O && !CPU_CLK_EN_O
    && !PERIPH_CLK_EN_O) else $error("clocks in active halt");
  a_halt_osc_off: assert property (MODE_O == 3'h3 |-> !OSC_RUN_O && !PERIPH_CLK_EN_O)
    else $error("oscillator on in halt");
  a_force_level: assert property (ILEVEL_FORCE_O |-> ILEVEL_O == 2'h2)
    else $error("forced level wrong");
  a_push_prio: assert property (PUSH_CC_O |-> SERVICE_IRQ_O && ILEVEL_O == IRQ_PRIORITY_I)
    else $error("pushed level wrong");
  a_halt_hold: assert property (MODE_O == 3'h3 && IRQ_PENDING_I == 0 && !WAKE_RESET_I
    |=> MODE_O == 3'h3) else $error("halt left without cause");
  a_ahalt_no_wdg: assert property (MODE_O == 3'h2 |-> !WATCHDOG_RESET_O)
    else $error("watchdog reset in active halt");
  a_wake_short: assert property ($past(MODE_O) == 3'h4 && MODE_O == 3'h0
    |-> dly_q >= WAKE_DELAY) else $error("wake delay short");
  a_wake_bound: assert property (MODE_O == 3'h4 |-> dly_q < MAXD)
    else $error("wake delay long");
endmodule // pm_props
bind power_saving_mode_controller pm_props #(.WAKE_DELAY(WAKE_DELAY), .NUM_IRQ(NUM_IRQ)) u_props (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .WFI_I(WFI_I), .HALT_I(HALT_I),
  .IRQ_PRIORITY_I(IRQ_PRIORITY_I), .CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
  .OSC_RUN_O(OSC_RUN_O), .ILEVEL_FORCE_O(ILEVEL_FORCE_O), .ILEVEL_O(ILEVEL_O),
  .SERVICE_IRQ_O(SERVICE_IRQ_O), .PUSH_CC_O(PUSH_CC_O), .IRQ_PENDING_I(IRQ_PENDING_I),
  .WAKE_RESET_I(WAKE_RESET_I), .WATCHDOG_ACTIVE_I(WATCHDOG_ACTIVE_I),
  .WATCHDOG_RESET_O(WATCHDOG_RESET_O), .MODE_O(MODE_O));

// ### verification/tb.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
module tb;
  reg clk, rst_n, cyc, stb, we, wait_for_interrupt_instr, halt, tbi, wdg, wds, wrst, fss, sss;
  reg [3:0] adr;
  reg [31:0] dw, q;
  reg [13:0] pend;
  wire [31:0] dr;
  wire ack, cen, pen, ten, frc, svc, push, wdr, osc, err, frs;
  wire [1:0] lvl, clvl, prio;
  wire [2:0] mode;
  integer errors, n_compared, i, nc, np, nt;
  power_saving_mode_controller #(.WAKE_DELAY(8)) dut (.CLK_I(clk), .RST_N_I(rst_n),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dw), .DAT_O(dr),
    .ACK_O(ack), .ERR_O(err), .WFI_I(wait_for_interrupt_instr), .HALT_I(halt), .CPU_ILEVEL_I(clvl),
    .IRQ_PRIORITY_I(prio), .CPU_CLK_EN_O(cen), .PERIPH_CLK_EN_O(pen), .OSC_RUN_O(osc),
    .TIMEBASE_CLK_EN_O(ten), .ILEVEL_FORCE_O(frc), .ILEVEL_O(lvl), .SERVICE_IRQ_O(svc),
    .FETCH_RESET_O(frs), .PUSH_CC_O(push), .IRQ_PENDING_I(pend), .TIMEBASE_IRQ_I(tbi),
    .WAKE_RESET_I(wrst), .WATCHDOG_ACTIVE_I(wdg), .WATCHDOG_RESET_O(wdr), .MODE_O(mode));
  cpu_core_model cpu (.clk_i(clk), .rst_n_i(rst_n), .force_i(frc), .level_i(lvl),
    .push_i(push), .level_o(clvl), .prio_o(prio));
  // Clock at 25 MHz
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Remember watchdog reset, reset vector and service pulses
  always @(posedge clk) begin
    if (!rst_n) {wds, fss, sss} <= 3'h0;
    else begin
      if (wdr === 1'b1) wds <= 1'b1;
      if (frs === 1'b1) fss <= 1'b1;
      if (svc === 1'b1) sss <= 1'b1;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, waits for the acknowledge
  task wb(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ack !== 1'b1 && n < 40);
      q = dr;
      if (n >= 40) chk(0, 1);
      {cyc, stb, we} <= 3'h0;
    end
  endtask
  // Count clock enable pulses over k cycles
  task cnt(input integer k);
    {nc, np, nt} = 0;
    repeat (k) begin
      @(posedge clk);
      nc += cen;
      np += pen;
      nt += ten;
    end
  endtask
  // One instruction pulse from the CPU
  task op(input w, input h);
    @(posedge clk);
    {wait_for_interrupt_instr, halt} <= {w, h};
    @(posedge clk);
    {wait_for_interrupt_instr, halt} <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  task wm(input [2:0] m);
    i = 0;
    while (mode !== m && i < 2000) begin
      @(posedge clk);
      i++;
    end
    chk(mode, m);
  endtask
  task print_verdict;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {errors, n_compared, wrst, cyc, stb, we, adr, dw, wait_for_interrupt_instr, halt, tbi, wdg, pend} = 0;
    rst_n = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    chk(mode, 0);
    wb(0, 4'h0, 0); chk(q, 0);
    wb(0, 4'h4, 0); chk(q[13:0], 14'h3FFF);
    wb(0, 4'h2, 0); chk(q[0], 1);
    wb(1, 4'h7, 32'hFF); wb(0, 4'h7, 0); chk(q, 0); chk(err, 0);
    cnt(64); chk(nc, 32); chk(np, 32);
    for (int k = 0; k < 4; k++) begin
      wb(1, 4'h0, 4 | k); repeat (64) @(posedge clk); cnt(256); chk(nc, 64 >> k);
    end
    wb(1, 4'h0, 5); op(1, 0); chk(mode, 1); chk(clvl, 2);
    cnt(64); chk(nc, 0); chk(np, 8);
    pend <= 14'h4; wm(0); @(posedge clk); chk(clvl, 1); chk(sss, 1); pend <= 0;
    wb(1, 4'h0, 0); wb(1, 4'h1, 1); op(0, 1); chk(mode, 2); chk(clvl, 2);
    cnt(64); chk(nc, 0); chk(nt > 0, 1);
    tbi <= 1; wm(4); wm(0); chk(i >= 14, 1); tbi <= 0;
    wb(1, 4'h1, 0); wb(1, 4'h4, 14'h3FFB); wdg <= 1; op(0, 1);
    chk(mode, 3); chk(osc, 0); chk(wds, 0);
    tbi <= 1; pend <= 14'h4; repeat (20) @(posedge clk); chk(mode, 3);
    pend <= 14'h1; wm(4); wm(0); chk(osc, 1); {tbi, pend} <= 0;
    wb(1, 4'h2, 0); pend <= 14'h1; op(0, 1); chk(wds, 1);
    wm(0); chk(i < 60, 1);
    pend <= 0; op(1, 0); chk(mode, 1); wrst <= 1; wm(0); @(posedge clk); chk(fss, 1);
    wrst <= 0;
    print_verdict;
  end
  // Cut a hang short
  initial begin
    #2000000;
    errors++;
    print_verdict;
  end
endmodule // tb
